//--- design/mmf_pkg.sv
// shared constants, types and helpers of the miscellaneous message framer
package mmf_pkg;
  localparam int WORD_W = 32;
  localparam int BODY_WORDS = 9;
  localparam int MAX_WORDS = 10;
  localparam int PAY_MAX = 32;
  localparam logic [5:0] PAY_MIN_BYTES = 6'h02;
  localparam logic [5:0] PAY_MAX_BYTES = 6'h20;
  localparam int HDR_PAY = 2;
  localparam logic [3:0] MISC_CLASS = 4'h7;
  localparam logic [2:0] EXT_ERR_KIND = 3'h6;
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_CREDIT_EXCH = 4'h1;
  localparam logic [3:0] OP_PER = 4'h2;
  localparam logic [3:0] OP_CREDITED_MIN = 4'h8;
  localparam int HDR_EXT_BIT = 7;
  localparam int EXT_MORE_BIT = 7;
  localparam int EXT_KIND_LSB = 4;
  localparam int CX_DATA_BYTE = 2;
  localparam int CX_REQ_BYTE = 3;
  localparam int CX_MISC_BYTE = 6;
  localparam int CX_SNOOP_BYTE = 7;
  localparam int ERR_P0_BYTE = 2;
  localparam int ERR_P1_BYTE = 3;
  localparam logic [4:0] NOP_WORDS = 5'h01;
  localparam logic [4:0] CX_WORDS = 5'h02;

  typedef enum logic [2:0] {
    MMF_NOP = 3'h0,
    MMF_CREDIT_EXCH = 3'h1,
    MMF_PER = 3'h2,
    MMF_UNCREDITED = 3'h3,
    MMF_CREDITED = 3'h4
  } mmf_kind_e;

  function automatic mmf_kind_e kind_of(input logic [3:0] op);
    if (op == OP_NOP) return MMF_NOP;
    if (op == OP_CREDIT_EXCH) return MMF_CREDIT_EXCH;
    if (op == OP_PER) return MMF_PER;
    if (op >= OP_CREDITED_MIN) return MMF_CREDITED;
    return MMF_UNCREDITED;
  endfunction

  // credit-exchange and nop headers never carry piggybacked credits
  function automatic logic credit_allowed(input mmf_kind_e k);
    return !(k == MMF_NOP || k == MMF_CREDIT_EXCH);
  endfunction

  // message length in words, extensions excluded
  function automatic logic [4:0] body_words(input mmf_kind_e k, input logic [5:0] n);
    logic [6:0] s;
    s = 7'({1'b0, n} + 7'h05);
    if (k == MMF_NOP) return NOP_WORDS;
    if (k == MMF_CREDIT_EXCH) return CX_WORDS;
    return 5'(s >> 2);
  endfunction
endpackage

//--- design/mmf_link_if.sv
// word stream between the sending and the receiving message agent
`timescale 1ns/1ns
`default_nettype none
interface mmf_link_if;
  logic [31:0] word;
  logic valid;
  logic ready;
  logic last;
  modport tx (output word, output valid, output last, input ready);
  modport rx (input word, input valid, input last, output ready);
endinterface
`default_nettype wire

//--- design/mmf_tx.sv
// sending end: builds miscellaneous messages and streams them word by word
`timescale 1ns/1ns
`default_nettype none
module mmf_tx (
  input wire logic clock,
  input wire logic sys_rst,
  mmf_link_if.tx lnk,
  input wire logic single_message_per_packet,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [3:0] req_opcode,
  input wire logic [1:0] req_credit,
  input wire logic [255:0] req_payload,
  input wire logic [5:0] req_payload_bytes,
  input wire logic [7:0] req_payload_credit_grant,
  input wire logic [7:0] req_request_credit_grant,
  input wire logic [7:0] req_aux_credit_grant,
  input wire logic [7:0] req_snoop_credit_grant,
  input wire logic req_err_valid,
  input wire logic [1:0] req_response_error_code,
  input wire logic [7:0] req_poison0,
  input wire logic [7:0] req_poison1
);
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01
  } mmf_tx_st_e;

  typedef struct packed {
    mmf_tx_st_e st;
    logic [3:0] idx;
    logic [3:0] cnt;
    logic [mmf_pkg::MAX_WORDS-1:0][31:0] words;
  } mmf_tx_s;

  mmf_tx_s q;
  mmf_tx_s d;
  logic [mmf_pkg::BODY_WORDS*4-1:0][7:0] body;
  logic [31:0] ext_w;
  logic [5:0] n;
  logic [4:0] len;
  logic [1:0] cr;
  logic ext;
  mmf_pkg::mmf_kind_e kind;

  always_comb begin
    d = q;
    body = '0;
    ext_w = '0;
    kind = mmf_pkg::kind_of(req_opcode);
    // R5: payload sized 2 to 32 bytes
    n = req_payload_bytes;
    if (n < mmf_pkg::PAY_MIN_BYTES) n = mmf_pkg::PAY_MIN_BYTES;
    if (n > mmf_pkg::PAY_MAX_BYTES) n = mmf_pkg::PAY_MAX_BYTES;
    // R7: length rounds up to whole words
    len = mmf_pkg::body_words(kind, n);
    // R9: no credits in exchange or nop
    cr = mmf_pkg::credit_allowed(kind) ? req_credit : 2'h0;
    // R1: pad a lone 4-byte message
    ext = req_err_valid || (single_message_per_packet && len == mmf_pkg::NOP_WORDS);
    // R14: extension flag in header
    body[0] = {ext, mmf_pkg::MISC_CLASS, len[4:2]};
    // R4: credit above opcode in byte 1
    body[1] = {len[1:0], cr, req_opcode};
    unique case (kind)
      // R11: credit grants in both words
      mmf_pkg::MMF_CREDIT_EXCH: begin
        body[mmf_pkg::CX_DATA_BYTE] = req_payload_credit_grant;
        body[mmf_pkg::CX_REQ_BYTE] = req_request_credit_grant;
        body[mmf_pkg::CX_MISC_BYTE] = req_aux_credit_grant;
        body[mmf_pkg::CX_SNOOP_BYTE] = req_snoop_credit_grant;
      end
      // R12: nop is header word only
      mmf_pkg::MMF_NOP: begin
      end
      default: begin
        // R6: R8: R13: R16: payload ascending, rest zero
        for (int i = 0; i < mmf_pkg::PAY_MAX; i++) begin
          if (6'(i) < n) body[i + mmf_pkg::HDR_PAY] = req_payload[8*i +: 8];
        end
      end
    endcase
    // R15: R2: error extension, code and poison bytes zero when clean
    ext_w[7:0] = {1'b0, mmf_pkg::EXT_ERR_KIND, 2'h0,
                  req_err_valid ? req_response_error_code : 2'h0};
    ext_w[8*mmf_pkg::ERR_P0_BYTE +: 8] = req_err_valid ? req_poison0 : 8'h00;
    ext_w[8*mmf_pkg::ERR_P1_BYTE +: 8] = req_err_valid ? req_poison1 : 8'h00;
    unique case (q.st)
      TX_IDLE: begin
        if (req_valid) begin
          d.st = TX_SEND;
          d.idx = 4'h0;
          d.cnt = 4'(len + {4'h0, ext});
          d.words = '0;
          d.words[0] = body[3:0];
          if (ext) d.words[1] = ext_w;
          for (int j = 1; j < mmf_pkg::BODY_WORDS; j++) begin
            if (ext) d.words[j + 1] = body[4*j +: 4];
            else d.words[j] = body[4*j +: 4];
          end
        end
      end
      TX_SEND: begin
        if (lnk.ready) begin
          if (q.idx == 4'(q.cnt - 4'h1)) d.st = TX_IDLE;
          else d.idx = 4'(q.idx + 4'h1);
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) q <= '0;
    else q <= d;
  end

  assign req_ready = (q.st == TX_IDLE);
  assign lnk.valid = (q.st == TX_SEND);
  assign lnk.word = q.words[q.idx];
  assign lnk.last = (q.st == TX_SEND) && (q.idx == 4'(q.cnt - 4'h1));
endmodule
`default_nettype wire

//--- design/mmf_rx.sv
// receiving end: parses miscellaneous messages and keeps the credit count
// How it works
// R1: lone 4-byte message padded with error extension
// R2: clean padding extension carries all zeros; the code still sets its kind field to six
// R3: 2-bit credit count added to available credits
// R4: opcode byte1 low, payload starts byte 2
// R5: payload two to thirty-two bytes, ascending
// R6: length field bounds extracted payload bytes
// R7: messages end on word boundary, rest reserved
// R8: uncredited form: opcode, same sizing
// R9: exchange and nop credit bits are reserved
// R10: error and generic messages return credits
// R11: credit exchange: two words of grants
// R12: nop is single header word
// R13: error message: credit, opcode, long payload
// R14: header bit flags following extension word
// R15: extension six: error code, two poison bytes
// R16: reserved bits zero sent, ignored received
`timescale 1ns/1ns
`default_nettype none
module mmf_rx #(
  parameter int CREDIT_W = 8
) (
  input wire logic clock,
  input wire logic sys_rst,
  mmf_link_if.rx lnk,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [3:0] rx_message_class,
  output logic [3:0] rx_opcode,
  output mmf_pkg::mmf_kind_e rx_kind,
  output logic [1:0] rx_credit,
  output logic [255:0] rx_payload,
  output logic [5:0] rx_payload_bytes,
  output logic [7:0] rx_payload_credit_grant,
  output logic [7:0] rx_request_credit_grant,
  output logic [7:0] rx_aux_credit_grant,
  output logic [7:0] rx_snoop_credit_grant,
  output logic rx_err_seen,
  output logic [1:0] rx_response_error_code,
  output logic [7:0] rx_poison0,
  output logic [7:0] rx_poison1,
  output logic rx_frame_error,
  input wire logic credit_use,
  output logic [CREDIT_W-1:0] credit_avail
);
  typedef enum logic [1:0] {
    RX_HDR = 2'b00,
    RX_EXT = 2'b01,
    RX_BODY = 2'b11,
    RX_HOLD = 2'b10
  } mmf_rx_st_e;

  typedef struct packed {
    mmf_rx_st_e st;
    logic [3:0] cls;
    logic [3:0] op;
    mmf_pkg::mmf_kind_e kind;
    logic [1:0] cr;
    logic [4:0] len;
    logic [3:0] widx;
    logic [mmf_pkg::BODY_WORDS*4-1:0][7:0] body;
    logic err_seen;
    logic [1:0] err;
    logic [7:0] p0;
    logic [7:0] p1;
    logic ferr;
    logic [CREDIT_W-1:0] credits;
  } mmf_rx_s;

  mmf_rx_s q;
  mmf_rx_s d;
  logic [7:0] b0;
  logic [7:0] b1;
  logic [4:0] hlen;
  logic done;
  logic [1:0] add;
  logic [CREDIT_W:0] sum;
  logic [6:0] pb;

  assign b0 = lnk.word[7:0];
  assign b1 = lnk.word[15:8];
  // R14: length field straddles bytes 0 and 1
  assign hlen = {b0[2:0], b1[7:6]};

  always_comb begin
    d = q;
    done = 1'b0;
    d.ferr = 1'b0;
    unique case (q.st)
      RX_HDR: begin
        if (lnk.valid) begin
          d.body = '0;
          d.body[3:0] = lnk.word;
          d.cls = b0[6:3];
          // R4: R8: opcode in byte 1 low bits
          d.op = b1[3:0];
          d.kind = mmf_pkg::kind_of(b1[3:0]);
          // R3: R9: R10: count only where permitted
          d.cr = mmf_pkg::credit_allowed(mmf_pkg::kind_of(b1[3:0])) ? b1[5:4] : 2'h0;
          // zero length is treated as a lone header word
          d.len = (hlen == 5'h00) ? 5'h01 : hlen;
          d.widx = 4'h1;
          d.err_seen = 1'b0;
          d.err = 2'h0;
          d.p0 = 8'h00;
          d.p1 = 8'h00;
          // R14: extension word follows when flagged
          if (b0[mmf_pkg::HDR_EXT_BIT]) begin
            d.st = RX_EXT;
          end else if (hlen <= 5'h01) begin
            // R12: single-word message completes here
            done = 1'b1;
            d.ferr = !lnk.last;
          end else begin
            d.st = RX_BODY;
          end
        end
      end
      RX_EXT: begin
        if (lnk.valid) begin
          // R15: only kind six is kept, others dropped
          if (lnk.word[mmf_pkg::EXT_KIND_LSB +: 3] == mmf_pkg::EXT_ERR_KIND) begin
            d.err_seen = 1'b1;
            d.err = b0[1:0];
            d.p0 = lnk.word[8*mmf_pkg::ERR_P0_BYTE +: 8];
            d.p1 = lnk.word[8*mmf_pkg::ERR_P1_BYTE +: 8];
          end
          if (!lnk.word[mmf_pkg::EXT_MORE_BIT]) begin
            if (q.len <= 5'h01) begin
              // R1: padded lone word ends at its extension
              done = 1'b1;
              d.ferr = !lnk.last;
            end else begin
              d.st = RX_BODY;
            end
          end
        end
      end
      RX_BODY: begin
        if (lnk.valid) begin
          // R5: R11: R13: words stored in ascending order
          d.body[4*q.widx +: 4] = lnk.word;
          d.widx = 4'(q.widx + 4'h1);
          // R6: stop at the length field, capped at the buffer
          if (5'(q.widx) == 5'(q.len - 5'h01)
              || q.widx == 4'(mmf_pkg::BODY_WORDS - 1)) begin
            done = 1'b1;
            d.ferr = !lnk.last || (q.len > 5'(mmf_pkg::BODY_WORDS));
          end
        end
      end
      RX_HOLD: begin
        if (rx_ready) begin
          d.st = RX_HDR;
        end
      end
    endcase
    if (done) begin
      d.st = RX_HOLD;
    end
    // R3: R10: add returned credits, saturating
    // a header-only message completes in the cycle its credit field arrives
    add = 2'h0;
    if (done) begin
      add = (q.st == RX_HDR) ? d.cr : q.cr;
    end
    sum = {1'b0, q.credits} + {{(CREDIT_W-1){1'b0}}, add};
    if (credit_use && sum != '0) begin
      sum = sum - 1'b1;
    end
    // clamp rather than wrap, which would drop credits the peer gave
    d.credits = sum[CREDIT_W] ? '1 : sum[CREDIT_W-1:0];
  end

  always_ff @(posedge clock) begin
    if (sys_rst) q <= '0;
    else q <= d;
  end

  // reading stalls while a parsed message waits for the user
  assign lnk.ready = (q.st != RX_HOLD);
  assign rx_valid = (q.st == RX_HOLD);
  assign rx_message_class = q.cls;
  assign rx_opcode = q.op;
  assign rx_kind = q.kind;
  assign rx_credit = q.cr;
  // R16: bytes 2 to 33 are reported whatever the length, reserved ones included
  assign rx_payload = q.body[mmf_pkg::HDR_PAY +: mmf_pkg::PAY_MAX];
  assign pb = 7'({q.len, 2'b00} - 7'h02);
  always_comb begin
    if (q.kind == mmf_pkg::MMF_NOP || q.kind == mmf_pkg::MMF_CREDIT_EXCH)
      rx_payload_bytes = 6'h00;
    else if (pb > 7'(mmf_pkg::PAY_MAX))
      rx_payload_bytes = mmf_pkg::PAY_MAX_BYTES;
    else
      rx_payload_bytes = pb[5:0];
  end
  // R11: grants read from both words
  assign rx_payload_credit_grant = q.body[mmf_pkg::CX_DATA_BYTE];
  assign rx_request_credit_grant = q.body[mmf_pkg::CX_REQ_BYTE];
  assign rx_aux_credit_grant = q.body[mmf_pkg::CX_MISC_BYTE];
  assign rx_snoop_credit_grant = q.body[mmf_pkg::CX_SNOOP_BYTE];
  assign rx_err_seen = q.err_seen;
  assign rx_response_error_code = q.err;
  assign rx_poison0 = q.p0;
  assign rx_poison1 = q.p1;
  assign rx_frame_error = q.ferr;
  assign credit_avail = q.credits;
endmodule
`default_nettype wire

//--- tb/mmf_link_props.sv
// assertions on the word stream between the two message agents
`timescale 1ns/1ns
`default_nettype none
module mmf_link_props (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [31:0] word,
  input wire logic valid,
  input wire logic ready,
  input wire logic last
);
  logic hdr_q;
  logic ext_q;
  logic hdr;
  logic [4:0] len;
  logic [3:0] op;
  assign hdr = valid && hdr_q;
  assign len = {word[2:0], word[15:14]};
  assign op = word[11:8];
  // next word is a header only once the previous message closed
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hdr_q <= 1'b1;
      ext_q <= 1'b0;
    end else if (valid && ready) begin
      hdr_q <= last;
      ext_q <= (hdr_q || ext_q) && word[7];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  hold_word_a: assert property (
    valid && !ready |=> valid && $stable(word) && $stable(last)) else $error("word changed in stall");
  class_field_a: assert property (
    hdr |-> word[6:3] == mmf_pkg::MISC_CLASS) else $error("bad message class");
  ext_kind_a: assert property (
    valid && ext_q |-> word[6:4] == mmf_pkg::EXT_ERR_KIND && !word[7]) else $error("bad ext kind");
  ext_rsvd_a: assert property (
    valid && ext_q |-> word[15:8] == 8'h00 && word[3:2] == 2'h0) else $error("ext reserved set");
  nop_shape_a: assert property (
    hdr && op == mmf_pkg::OP_NOP |-> len == 5'h01 && word[31:16] == 16'h0000
      && word[13:12] == 2'h0)
    else $error("bad nop header");
  cx_shape_a: assert property (
    hdr && op == mmf_pkg::OP_CREDIT_EXCH |-> len == 5'h02 && word[13:12] == 2'h0 && !word[7])
    else $error("bad exchange header");
  len_range_a: assert property (
    hdr && op >= mmf_pkg::OP_PER |-> len >= 5'h01 && len <= 5'h09) else $error("bad length");
  lone_last_a: assert property (
    hdr && last |-> len == 5'h01 && !word[7]) else $error("early last");
  idle_gap_a: assert property (
    valid && ready && last |=> !valid) else $error("no idle gap");
  cover property (valid && ext_q);
  cover property (hdr && op == mmf_pkg::OP_CREDIT_EXCH);
  cover property (valid && !ready);
endmodule
`default_nettype wire

//--- tb/misc_message_framer_tb.sv
// testbench joining sending and receiving ends back to back
`timescale 1ns/1ns
`default_nettype none
module misc_message_framer_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic single_message_per_packet = 1'b0;
  logic req_valid = 1'b0;
  logic req_err_valid = 1'b0;
  logic rx_ready = 1'b0;
  logic credit_use = 1'b0;
  logic [3:0] req_opcode = 4'h0;
  logic [1:0] req_credit = 2'h0;
  logic [1:0] req_response_error_code = 2'h2;
  logic [255:0] req_payload;
  logic [5:0] req_payload_bytes = 6'h02;
  logic [7:0] req_payload_credit_grant = 8'h11;
  logic [7:0] req_request_credit_grant = 8'h22;
  logic [7:0] req_aux_credit_grant = 8'h33;
  logic [7:0] req_snoop_credit_grant = 8'h44;
  logic [7:0] req_poison0 = 8'hA5;
  logic [7:0] req_poison1 = 8'h5A;
  logic req_ready, rx_valid, rx_err_seen, rx_frame_error;
  logic [3:0] rx_message_class, rx_opcode;
  mmf_pkg::mmf_kind_e rx_kind;
  logic [1:0] rx_credit, rx_response_error_code;
  logic [255:0] rx_payload;
  logic [5:0] rx_payload_bytes;
  logic [7:0] rx_payload_credit_grant, rx_request_credit_grant, rx_aux_credit_grant;
  logic [7:0] rx_snoop_credit_grant, rx_poison0, rx_poison1, credit_avail;
  logic [7:0] exp_cr = 8'h00;
  int checks = 0;
  int fails = 0;
  mmf_link_if lnk ();
  mmf_tx u_mmf_tx (.clock, .sys_rst, .lnk(lnk), .single_message_per_packet, .req_valid,
    .req_ready, .req_opcode, .req_credit, .req_payload, .req_payload_bytes,
    .req_payload_credit_grant, .req_request_credit_grant, .req_aux_credit_grant,
    .req_snoop_credit_grant, .req_err_valid, .req_response_error_code, .req_poison0,
    .req_poison1);
  mmf_rx #(.CREDIT_W(8)) u_mmf_rx (.clock, .sys_rst, .lnk(lnk), .rx_valid, .rx_ready,
    .rx_message_class, .rx_opcode, .rx_kind, .rx_credit, .rx_payload, .rx_payload_bytes,
    .rx_payload_credit_grant, .rx_request_credit_grant, .rx_aux_credit_grant,
    .rx_snoop_credit_grant, .rx_err_seen, .rx_response_error_code, .rx_poison0, .rx_poison1,
    .rx_frame_error, .credit_use, .credit_avail);
  mmf_link_props u_mmf_link_props (.clock, .sys_rst, .word(lnk.word), .valid(lnk.valid),
    .ready(lnk.ready), .last(lnk.last));
  always #25 clock = ~clock;
  task automatic chk(input logic [255:0] s, input logic [255:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic put(input logic [3:0] o, input logic [1:0] c, input logic [5:0] n,
    input logic e, input logic s);
    for (int i = 0; i < 50 && req_ready !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    chk(req_ready, 1'b1);
    @(posedge clock);
    req_valid <= 1'b1;
    req_opcode <= o;
    req_credit <= c;
    req_payload_bytes <= n;
    req_err_valid <= e;
    single_message_per_packet <= s;
    @(posedge clock);
    req_valid <= 1'b0;
  endtask
  task automatic get;
    #1;
    for (int i = 0; i < 60 && rx_valid !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    chk(rx_valid, 1'b1);
    chk(rx_frame_error, 1'b0);
    chk(rx_message_class, mmf_pkg::MISC_CLASS);
  endtask
  task automatic ack;
    @(posedge clock);
    rx_ready <= 1'b1;
    @(posedge clock);
    rx_ready <= 1'b0;
    #1;
    chk(credit_avail, exp_cr);
  endtask
  task automatic t_credited;
    put(4'h8, 2'h3, 6'h02, 1'b0, 1'b1);
    get;
    chk({rx_kind, rx_opcode, rx_credit}, {mmf_pkg::MMF_CREDITED, 4'h8, 2'h3});
    chk({rx_payload_bytes, rx_payload[15:0]}, {6'h02, req_payload[15:0]});
    chk({rx_err_seen, rx_response_error_code, rx_poison0, rx_poison1}, 19'h40000);
    exp_cr = exp_cr + 8'h03;
    ack;
    $display("test credited done");
  endtask
  task automatic t_long;
    put(4'h3, 2'h2, 6'h20, 1'b0, 1'b0);
    get;
    chk({rx_kind, rx_payload_bytes, rx_err_seen}, {mmf_pkg::MMF_UNCREDITED, 6'h20, 1'b0});
    chk(rx_payload, req_payload);
    exp_cr = exp_cr + 8'h02;
    ack;
    $display("test long done");
  endtask
  task automatic t_odd;
    put(4'h9, 2'h0, 6'h05, 1'b0, 1'b0);
    get;
    chk(rx_payload_bytes, 6'h06);
    chk(rx_payload[47:0], {8'h00, req_payload[39:0]});
    ack;
    $display("test odd done");
  endtask
  task automatic t_exchange;
    put(4'h1, 2'h3, 6'h02, 1'b0, 1'b0);
    get;
    chk({rx_kind, rx_credit}, {mmf_pkg::MMF_CREDIT_EXCH, 2'h0});
    chk({rx_payload_credit_grant, rx_request_credit_grant, rx_aux_credit_grant,
      rx_snoop_credit_grant}, 32'h11223344);
    ack;
    $display("test exchange done");
  endtask
  task automatic t_stall;
    put(4'h2, 2'h1, 6'h20, 1'b1, 1'b1);
    get;
    put(4'h0, 2'h3, 6'h02, 1'b0, 1'b1);
    repeat (6) @(posedge clock);
    #1;
    chk(req_ready, 1'b0);
    chk({rx_kind, rx_credit}, {mmf_pkg::MMF_PER, 2'h1});
    chk(rx_payload, req_payload);
    chk({rx_err_seen, rx_response_error_code, rx_poison0, rx_poison1}, 19'h6A55A);
    exp_cr = exp_cr + 8'h01;
    ack;
    get;
    chk({rx_kind, rx_credit, rx_err_seen}, {mmf_pkg::MMF_NOP, 2'h0, 1'b1});
    ack;
    $display("test stall done");
  endtask
  task automatic t_use;
    @(posedge clock);
    credit_use <= 1'b1;
    @(posedge clock);
    credit_use <= 1'b0;
    #1;
    chk(credit_avail, exp_cr - 8'h01);
    $display("test use done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 32; i++) begin
      req_payload[8*i+:8] = 8'h40 + 8'(i);
    end
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    t_credited;
    t_long;
    t_odd;
    t_exchange;
    t_stall;
    t_use;
    report_and_stop;
  end
  // whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clock);
    fails++;
    report_and_stop;
  end
endmodule
`default_nettype wire
